// file: rtl/reset_source_controller.sv
// reset source controller: pin noise filter, power-on boot sequence,
// brown-out reset, cause flags and a small register port.
// assumes all inputs synchronous to clock; option memory word is stable
// whenever the configuration read state is reached.
//
// Behaviour
// - ignore reset pin lows shorter than 2us
// - hold reset while power-on detector active
// - wait osc/8 x 256 x 0x28 before config
// - load option configuration before releasing reset
// - hold reset until 16ms interval timer overflow
// - wait 16ms after pin returns high
// - sequencing step lasts 5 oscillator clocks
// - execution starts at vector address zero
// - brown-out compares supply to selected level
// - power-on flag set by POR, software clears
// - pin flag set by pin, cleared by write only
// - watchdog flag set by overflow, cleared by write/POR
// - debug flag set by debug reset, cleared likewise
// - low-voltage flag set by brown-out, cleared by write only
// - POR sets power-on, clears watchdog and debug
// - POR leaves pin/low-voltage flags to their own sources
// - other resets set only their own flag
// - five reset sources with enable conditions
// - brown-out active when disable bit zero
`timescale 1ns/1ps
module reset_source_controller
    import reset_source_pkg::*;
#(
    parameter int filter_cycles     = reset_source_pkg::FILTER_CYCLES,
    parameter int boot_delay_cycles = reset_source_pkg::BOOT_DELAY_CYCLES,
    parameter int stable_cycles     = reset_source_pkg::STABLE_CYCLES,
    parameter int step_cycles       = reset_source_pkg::STEP_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        reset_pin_n,
    input  wire logic        por_detect,
    input  wire logic        watchdog_overflow,
    input  wire logic        watchdog_enable,
    input  wire logic        debug_reset_req,
    input  wire logic [15:0] supply_mv,
    input  wire logic [7:0]  option_word,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    output logic             core_reset,
    output logic      [7:0]  config_value,
    output logic      [15:0] reset_vector
);
    import reset_source_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the timer is 24 bits and the pin counter 16, so longer counts cannot be served
    if (filter_cycles < 2 || filter_cycles > 65535) begin : filter_range_check
        $error("reset_source_controller: filter_cycles out of range");
    end
    if (boot_delay_cycles < 1 || boot_delay_cycles > 16_000_000) begin : boot_range_check
        $error("reset_source_controller: boot_delay_cycles out of range");
    end
    if (stable_cycles < 1 || stable_cycles > 16_000_000) begin : stable_range_check
        $error("reset_source_controller: stable_cycles out of range");
    end
    if (step_cycles < 1 || step_cycles > 16_000_000) begin : step_range_check
        $error("reset_source_controller: step_cycles out of range");
    end

    typedef enum logic [2:0] {
        st_por_hold, st_boot_delay, st_config_read, st_source_hold,
        st_stabilize, st_step, st_run
    } seq_state_type;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    seq_state_type state_reg, state_next;
    logic [23:0]   timer_reg, timer_next;
    logic [15:0]   pin_low_count_reg, pin_low_count_next;
    logic [7:0]    cause_flags_reg, cause_flags_next;
    logic [7:0]    lvr_control_reg, lvr_control_next;
    logic [7:0]    lvi_control_reg, lvi_control_next;
    logic [7:0]    config_value_reg;
    logic [7:0]    reg_rdata_reg, reg_rdata_next;
    logic          core_reset_reg;

    // ------------------------------------------------------------
    // reset pin noise filter
    // ------------------------------------------------------------
    // the count saturates, so a long hold keeps the source asserted
    wire pin_low_full = (pin_low_count_reg == 16'(filter_cycles));
    wire pin_event    = !reset_pin_n && (pin_low_count_reg == 16'(filter_cycles - 1));
    wire pin_held     = !reset_pin_n && (pin_event || pin_low_full);
    assign pin_low_count_next = reset_pin_n  ? 16'h0000 :
                                pin_low_full ? pin_low_count_reg :
                                16'(pin_low_count_reg + 16'h0001);

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    wire       brownout_disable      = lvr_control_reg[DISABLE_BIT];
    wire [3:0] brownout_level_select = lvr_control_reg[LEVEL_LSB +: 4];
    // codes 14 and 15 have no level; the comparator never trips on them
    wire       level_valid  = (brownout_level_select < 4'(LEVEL_COUNT));
    wire [15:0] level_mv    = level_valid ? BROWNOUT_MV[brownout_level_select] : 16'h0000;
    wire       supply_below = level_valid && (supply_mv < level_mv);
    wire       lvr_active   = !brownout_disable && supply_below;
    wire       wdt_event    = watchdog_overflow && watchdog_enable;
    wire       any_source   = pin_held || lvr_active || wdt_event || debug_reset_req;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wire boot_done   = (timer_reg == 24'(boot_delay_cycles - 1));
    wire stable_done = (timer_reg == 24'(stable_cycles - 1));
    wire step_done   = (timer_reg == 24'(step_cycles - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_por_hold:    if (!por_detect) state_next = st_boot_delay;
            st_boot_delay:  if (boot_done) state_next = st_config_read;
            st_config_read: state_next = st_stabilize;
            st_source_hold: if (!pin_held && !lvr_active) state_next = st_stabilize;
            st_stabilize: begin
                if (any_source) state_next = st_source_hold;
                else if (stable_done) state_next = st_step;
            end
            st_step: begin
                if (any_source) state_next = st_source_hold;
                else if (step_done) state_next = st_run;
            end
            st_run:         if (any_source) state_next = st_source_hold;
            default:        state_next = st_por_hold;
        endcase
        if (por_detect) begin
            state_next = st_por_hold;
        end
    end

    assign timer_next = (state_next != state_reg) ? 24'h000000 : 24'(timer_reg + 24'h000001);

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire sel_flags = (reg_addr == CAUSE_FLAGS_ADDR);
    wire sel_lvr   = (reg_addr == LVR_CONTROL_ADDR);
    wire sel_lvi   = (reg_addr == LVI_CONTROL_ADDR);
    wire wr_flags  = reg_write && sel_flags;
    wire wr_lvr    = reg_write && sel_lvr;
    wire wr_lvi    = reg_write && sel_lvi;

    // a written zero clears a flag, a written one leaves it alone
    wire [7:0] flag_clear = wr_flags ? ~reg_wdata : 8'h00;
    wire [7:0] flag_set   = {1'b0, pin_event, wdt_event, debug_reset_req, lvr_active, 3'b000};

    // set wins over a same-cycle software clear
    assign cause_flags_next = por_detect ?
        ((cause_flags_reg & ~flag_clear & 8'h48) | flag_set | CAUSE_FLAGS_RESET) :
        (((cause_flags_reg & ~flag_clear) | flag_set) & CAUSE_FLAGS_MASK);

    // level select is cleared by power-on, kept by every other reset
    assign lvr_control_next = por_detect ? LVR_CONTROL_RESET :
                              wr_lvr ? (reg_wdata & LVR_CONTROL_MASK) : lvr_control_reg;
    assign lvi_control_next = wr_lvi ? reg_wdata : lvi_control_reg;

    wire [7:0] read_mux = sel_flags ? cause_flags_reg :
                          sel_lvr   ? lvr_control_reg :
                          sel_lvi   ? lvi_control_reg : 8'h00;
    assign reg_rdata_next = reg_read ? read_mux : 8'h00;

    // ------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg         <= st_por_hold;
            timer_reg         <= 24'h000000;
            pin_low_count_reg <= 16'h0000;
            core_reset_reg    <= 1'b1;
        end else begin
            state_reg         <= state_next;
            timer_reg         <= timer_next;
            pin_low_count_reg <= pin_low_count_next;
            core_reset_reg    <= (state_next != st_run);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cause_flags_reg <= CAUSE_FLAGS_RESET;
            lvr_control_reg <= LVR_CONTROL_RESET;
            lvi_control_reg <= LVI_CONTROL_RESET;
            reg_rdata_reg   <= 8'h00;
        end else begin
            cause_flags_reg <= cause_flags_next;
            lvr_control_reg <= lvr_control_next;
            lvi_control_reg <= lvi_control_next;
            reg_rdata_reg   <= reg_rdata_next;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            config_value_reg <= 8'h00;
        end else if (state_reg == st_config_read) begin
            config_value_reg <= option_word;
        end
    end

    assign reg_rdata    = reg_rdata_reg;
    assign core_reset   = core_reset_reg;
    assign config_value = config_value_reg;
    assign reset_vector = 16'h0000;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    short_pin_ignored_a: assert property (
        pin_event |-> $past(!reset_pin_n, 1) && $past(pin_low_count_reg, 1) ==
            16'(filter_cycles - 2))
        else $error("pin event without full filter interval");

    por_holds_reset_a: assert property (
        por_detect |=> core_reset && state_reg == st_por_hold)
        else $error("power-on detect did not hold reset");

    boot_delay_len_a: assert property (
        state_reg == st_config_read |-> $past(timer_reg) == 24'(boot_delay_cycles - 1))
        else $error("boot delay length wrong");

    config_load_a: assert property (
        state_reg == st_config_read && !por_detect |=> config_value == $past(option_word))
        else $error("configuration not loaded");

    stabilize_len_a: assert property (
        state_reg == st_step && $past(state_reg) == st_stabilize |->
            $past(timer_reg) == 24'(stable_cycles - 1))
        else $error("stabilization interval wrong");

    step_len_a: assert property (
        state_reg == st_run && $past(state_reg) == st_step |->
            $past(timer_reg) == 24'(step_cycles - 1))
        else $error("sequencing step length wrong");

    release_sync_a: assert property (
        $fell(core_reset) |-> state_reg == st_run && $past(state_reg) == st_step)
        else $error("reset released outside sequence");

    por_flags_a: assert property (
        por_detect |=> cause_flags_reg[POWER_ON_BIT] &&
            (!cause_flags_reg[WATCHDOG_BIT] || $past(wdt_event)) &&
            (!cause_flags_reg[DEBUG_BIT] || $past(debug_reset_req)))
        else $error("power-on flags wrong");

    watchdog_flag_a: assert property (
        wdt_event |=> cause_flags_reg[WATCHDOG_BIT])
        else $error("watchdog flag not set");

    flag_clear_a: assert property (
        wr_flags && !reg_wdata[POWER_ON_BIT] && !por_detect |=> !cause_flags_reg[POWER_ON_BIT])
        else $error("power-on flag not cleared by write");

    others_kept_a: assert property (
        !por_detect && !reg_write && !debug_reset_req |=>
            cause_flags_reg[DEBUG_BIT] == $past(cause_flags_reg[DEBUG_BIT]))
        else $error("debug flag changed without cause");

    brownout_gate_a: assert property (
        brownout_disable && !wdt_event && !debug_reset_req && !pin_held && !por_detect
            && state_reg == st_run |=> state_reg == st_run)
        else $error("disabled brown-out caused reset");

    pin_flag_set_a: assert property (
        pin_event |=> cause_flags_reg[PIN_BIT])
        else $error("pin flag not set");

    debug_flag_set_a: assert property (
        debug_reset_req |=> cause_flags_reg[DEBUG_BIT])
        else $error("debug flag not set");

    lowvolt_flag_set_a: assert property (
        lvr_active |=> cause_flags_reg[LOW_VOLT_BIT])
        else $error("low-voltage flag not set");

    pin_flag_kept_a: assert property (
        !pin_event && !wr_flags |=> $stable(cause_flags_reg[PIN_BIT]))
        else $error("pin flag changed without cause");

    lowvolt_kept_a: assert property (
        !lvr_active && !wr_flags |=> $stable(cause_flags_reg[LOW_VOLT_BIT]))
        else $error("low-voltage flag changed without cause");

    watchdog_kept_a: assert property (
        !wdt_event && !wr_flags && !por_detect |=> $stable(cause_flags_reg[WATCHDOG_BIT]))
        else $error("watchdog flag changed without cause");

    por_flag_kept_a: assert property (
        !wr_flags && !por_detect |=> $stable(cause_flags_reg[POWER_ON_BIT]))
        else $error("power-on flag changed without cause");

    pin_write_clear_a: assert property (
        wr_flags && !reg_wdata[PIN_BIT] && !pin_event |=> !cause_flags_reg[PIN_BIT])
        else $error("pin flag not cleared by write");

    debug_por_clear_a: assert property (
        por_detect && !debug_reset_req |=> !cause_flags_reg[DEBUG_BIT])
        else $error("debug flag kept over power-on");

    wd_gate_a: assert property (
        !watchdog_enable && !wr_flags && !por_detect |=> $stable(cause_flags_reg[WATCHDOG_BIT]))
        else $error("disabled watchdog changed its flag");

    pin_hold_reset_a: assert property (
        pin_held && !por_detect && state_reg == st_run |=> core_reset &&
            state_reg == st_source_hold)
        else $error("pin reset not taken");

    brownout_reset_a: assert property (
        lvr_active && !por_detect && state_reg == st_run |=> core_reset &&
            state_reg == st_source_hold)
        else $error("brown-out reset not taken");

    wdt_reset_a: assert property (
        wdt_event && !por_detect && state_reg == st_run |=> core_reset &&
            state_reg == st_source_hold)
        else $error("watchdog reset not taken");

    hold_stays_a: assert property (
        state_reg == st_source_hold && pin_held && !por_detect |=> state_reg == st_source_hold)
        else $error("hold left while pin low");

    stable_restart_a: assert property (
        state_reg == st_stabilize && any_source && !por_detect |=> state_reg == st_source_hold)
        else $error("source during stabilization ignored");

    step_restart_a: assert property (
        state_reg == st_step && any_source && !por_detect |=> state_reg == st_source_hold)
        else $error("source during step ignored");

    config_stable_a: assert property (
        state_reg != st_config_read |=> $stable(config_value))
        else $error("configuration changed outside read");

    config_from_boot_a: assert property (
        state_reg == st_config_read |-> $past(state_reg) == st_boot_delay)
        else $error("configuration read without boot delay");

    run_from_step_a: assert property (
        state_reg == st_run && $past(state_reg) != st_run |-> $past(state_reg) == st_step)
        else $error("run entered without step");

    level_clear_a: assert property (
        por_detect |=> lvr_control_reg == LVR_CONTROL_RESET)
        else $error("power-on did not clear level select");

    rdata_idle_a: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

    flags_read_a: assert property (
        $past(reg_read && sel_flags) |-> reg_rdata == $past(cause_flags_reg))
        else $error("flag read data wrong");

    por_boot_a: assert property (
        state_reg == st_por_hold && !por_detect |=> state_reg == st_boot_delay)
        else $error("boot delay not started");

    stable_hold_a: assert property (
        state_reg == st_stabilize && !stable_done && !any_source && !por_detect |=>
            state_reg == st_stabilize)
        else $error("stabilization ended early");

endmodule : reset_source_controller

// file: rtl/reset_source_pkg.sv
// constants for the reset source controller: register map, field positions,
// reset values, brown-out trigger table and timing counts.
// assumes a 100 MHz system clock and an 8-bit register port.
package reset_source_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ         = 100_000_000;
    localparam int BOOT_OSC_HZ      = 8_000_000;
    localparam int BOOT_PRESCALE    = 8;
    localparam int BOOT_TICKS       = 256;
    localparam int BOOT_MULT        = 'h28;
    localparam int NOISE_FILTER_NS  = 2000;
    localparam int STABLE_MS        = 16;
    localparam int STEP_OSC_CLOCKS  = 5;
    localparam int FILTER_CYCLES    = NOISE_FILTER_NS * (CLOCK_HZ / 1_000_000) / 1000;
    localparam int BOOT_DELAY_CYCLES = int'((longint'(CLOCK_HZ) * BOOT_PRESCALE * BOOT_TICKS
                                       * BOOT_MULT) / BOOT_OSC_HZ);
    localparam int STABLE_CYCLES    = STABLE_MS * (CLOCK_HZ / 1000);
    localparam int STEP_CYCLES      = (STEP_OSC_CLOCKS * CLOCK_HZ + BOOT_OSC_HZ - 1) / BOOT_OSC_HZ;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] LVI_CONTROL_ADDR   = 8'h86;
    localparam logic [7:0] LVR_CONTROL_ADDR   = 8'hD8;
    localparam logic [7:0] CAUSE_FLAGS_ADDR   = 8'hE8;
    localparam logic [7:0] LVI_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] LVR_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] CAUSE_FLAGS_RESET  = 8'h80;
    localparam logic [7:0] LVR_CONTROL_MASK   = 8'h9F;
    localparam logic [7:0] CAUSE_FLAGS_MASK   = 8'hF8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POWER_ON_BIT   = 7;
    localparam int PIN_BIT        = 6;
    localparam int WATCHDOG_BIT   = 5;
    localparam int DEBUG_BIT      = 4;
    localparam int LOW_VOLT_BIT   = 3;
    localparam int DISABLE_BIT    = 0;
    localparam int LEVEL_LSB      = 1;
    localparam int LEVEL_COUNT    = 14;

    // brown-out trigger levels in millivolts, indexed by level select
    localparam logic [15:0] BROWNOUT_MV [LEVEL_COUNT] = '{
        16'h0640, 16'h07D0, 16'h0834, 16'h0898, 16'h0910, 16'h0988, 16'h0A1E,
        16'h0ABE, 16'h0B72, 16'h0C44, 16'h0D34, 16'h0E56, 16'h0FA0, 16'h1130};

endpackage : reset_source_pkg

// file: tb/reset_source_controller_tb_top.sv
// self-checking bench for the reset source controller.
// assumes shortened counts: filter 4, boot 20, stable 30, step 3 cycles.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module reset_source_controller_tb_top;
    import reset_source_pkg::*;
    logic        clock, sys_rst, pin_hold, wd_fire, dbg_fire, por_detect, watchdog_enable;
    logic [15:0] supply_mv;
    logic [7:0]  option_word, reg_addr, reg_wdata, reg_rdata, config_value, rd_val;
    logic        reg_write, reg_read, core_reset, reset_pin_n, watchdog_overflow, debug_reset_req;
    logic [15:0] reset_vector;
    int          miscompares = 0;
    int          checked = 0;

    reset_source_partner reset_source_partner_inst (.pin_hold(pin_hold),
        .wd_fire(wd_fire), .dbg_fire(dbg_fire), .reset_pin_n(reset_pin_n),
        .watchdog_overflow(watchdog_overflow), .debug_reset_req(debug_reset_req));
    reset_source_controller #(.filter_cycles(4), .boot_delay_cycles(20), .stable_cycles(30),
        .step_cycles(3)) reset_source_controller_inst (.clock(clock), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .por_detect(por_detect),
        .watchdog_overflow(watchdog_overflow), .watchdog_enable(watchdog_enable),
        .debug_reset_req(debug_reset_req), .supply_mv(supply_mv), .option_word(option_word),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .core_reset(core_reset),
        .config_value(config_value), .reset_vector(reset_vector));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task chk_reg(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clock);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
        `CHK(nm, exp, rd_val)
        @(posedge clock);
        #1 `CHK("rdata idle", 8'h00, reg_rdata)
    endtask : chk_reg
    // reset must still stand after lo cycles and be gone by hi
    task rel(input int lo, input int hi);
        repeat (lo) @(posedge clock);
        #1 `CHK("reset held", 1'b1, core_reset)
        for (int i = 0; i < hi - lo && core_reset !== 1'b0; i++) @(posedge clock);
        #1 `CHK("reset released", 1'b0, core_reset)
    endtask : rel
    task cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_boot;
        rel(45, 70);
        `CHK("config", 8'h5A, config_value)
        `CHK("vector", 16'h0000, reset_vector)
        chk_reg(CAUSE_FLAGS_ADDR, 8'h80, "flags");
        chk_reg(LVR_CONTROL_ADDR, 8'h00, "lvr ctrl");
        chk_reg(LVI_CONTROL_ADDR, 8'h00, "lvi ctrl");
        $display("boot done");
    endtask : t_boot
    task t_regs;
        wr(LVI_CONTROL_ADDR, 8'hA5);
        chk_reg(LVI_CONTROL_ADDR, 8'hA5, "lvi ctrl");
        wr(LVR_CONTROL_ADDR, 8'hFF);
        chk_reg(LVR_CONTROL_ADDR, 8'h9F, "lvr ctrl");
        chk_reg(8'h00, 8'h00, "unmapped");
        wr(LVR_CONTROL_ADDR, 8'h00);
        wr(CAUSE_FLAGS_ADDR, 8'h00);
        chk_reg(CAUSE_FLAGS_ADDR, 8'h00, "flags");
        $display("regs done");
    endtask : t_regs
    task t_filter;
        @(posedge clock) pin_hold <= 1'b1;
        cycles(3);
        pin_hold <= 1'b0;
        cycles(5);
        #1 `CHK("glitch", 1'b0, core_reset)
        chk_reg(CAUSE_FLAGS_ADDR, 8'h00, "flags");
        $display("filter done");
    endtask : t_filter
    task t_pin;
        @(posedge clock) pin_hold <= 1'b1;
        cycles(10);
        pin_hold <= 1'b0;
        rel(25, 45);
        chk_reg(CAUSE_FLAGS_ADDR, 8'h40, "flags");
        $display("pin done");
    endtask : t_pin
    task t_sources;
        @(posedge clock) wd_fire <= 1'b1;
        @(posedge clock) wd_fire <= 1'b0;
        cycles(5);
        #1 `CHK("wd disabled", 1'b0, core_reset)
        @(posedge clock) watchdog_enable <= 1'b1;
        wd_fire <= 1'b1;
        @(posedge clock) wd_fire <= 1'b0;
        rel(25, 45);
        chk_reg(CAUSE_FLAGS_ADDR, 8'h60, "flags");
        @(posedge clock) dbg_fire <= 1'b1;
        @(posedge clock) dbg_fire <= 1'b0;
        rel(25, 45);
        chk_reg(CAUSE_FLAGS_ADDR, 8'h70, "flags");
        $display("sources done");
    endtask : t_sources
    task t_brownout;
        wr(LVR_CONTROL_ADDR, 8'h01);
        supply_mv <= 16'h05DC;
        cycles(5);
        #1 `CHK("bod disabled", 1'b0, core_reset)
        wr(LVR_CONTROL_ADDR, 8'h00);
        cycles(5);
        #1 `CHK("bod reset", 1'b1, core_reset)
        @(posedge clock) supply_mv <= 16'h1388;
        rel(25, 45);
        chk_reg(CAUSE_FLAGS_ADDR, 8'h78, "flags");
        $display("brownout done");
    endtask : t_brownout
    task t_levels;
        wr(LVR_CONTROL_ADDR, 8'h1C);
        supply_mv <= 16'h0000;
        cycles(5);
        #1 `CHK("code 14 idle", 1'b0, core_reset)
        @(posedge clock) supply_mv <= 16'h0988;
        wr(LVR_CONTROL_ADDR, 8'h0A);
        cycles(5);
        #1 `CHK("2.44V at level", 1'b0, core_reset)
        @(posedge clock) supply_mv <= 16'h0D34;
        wr(LVR_CONTROL_ADDR, 8'h14);
        cycles(5);
        #1 `CHK("3.38V at level", 1'b0, core_reset)
        @(posedge clock) supply_mv <= 16'h0D33;
        cycles(5);
        #1 `CHK("3.38V below", 1'b1, core_reset)
        @(posedge clock) supply_mv <= 16'h1388;
        rel(25, 45);
        wr(LVR_CONTROL_ADDR, 8'h00);
        $display("levels done");
    endtask : t_levels
    task t_por;
        @(posedge clock) por_detect <= 1'b1;
        option_word <= 8'hC3;
        cycles(5);
        #1 `CHK("por hold", 1'b1, core_reset)
        @(posedge clock) por_detect <= 1'b0;
        rel(45, 70);
        `CHK("config", 8'hC3, config_value)
        chk_reg(CAUSE_FLAGS_ADDR, 8'hC8, "flags");
        chk_reg(LVR_CONTROL_ADDR, 8'h00, "lvr ctrl");
        $display("por done");
    endtask : t_por

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        // whole run is well under 2000 cycles
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
    initial begin
        sys_rst = 1'b1; pin_hold = 1'b0; wd_fire = 1'b0; dbg_fire = 1'b0;
        por_detect = 1'b0; watchdog_enable = 1'b0; supply_mv = 16'h1388;
        option_word = 8'h5A; reg_addr = 8'h00; reg_wdata = 8'h00;
        reg_write = 1'b0; reg_read = 1'b0;
        cycles(6);
        sys_rst <= 1'b0;
        t_boot();
        t_regs();
        t_filter();
        t_pin();
        t_sources();
        t_brownout();
        t_levels();
        t_por();
        print_verdict();
    end
endmodule : reset_source_controller_tb_top

// file: tb/reset_source_partner.sv
// far-side model: external reset pin with pull-up and the watchdog and
// debug request lines; the bench commands each source through a level input.
`timescale 1ns/1ps
module reset_source_partner (
    input  wire logic pin_hold,
    input  wire logic wd_fire,
    input  wire logic dbg_fire,
    output logic      reset_pin_n,
    output logic      watchdog_overflow,
    output logic      debug_reset_req
);
    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    // released pin goes to its pull-up level, never holds the last value
    assign reset_pin_n       = pin_hold ? 1'b0 : 1'b1;
    // overflow is raised regardless of enable; gating is the device's job
    assign watchdog_overflow = wd_fire;
    assign debug_reset_req   = dbg_fire;
endmodule : reset_source_partner
